// File: eefe_bus_master.sv
`timescale 1ns/100ps

// bus master model; scl rests high between frames, a released sda reads high
module eefe_bus_master (
   output logic      o_scl,
   output logic      o_sda,
   input  wire logic i_sda
);
   logic in_frame;

   // idle bus at power-up
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      in_frame = 1'b0;
   end

   // start; inside a frame scl is lowered first to make a repeated start
   task automatic start_cond();
      if (in_frame)
      begin
         o_scl = 1'b0;
         #250 o_sda = 1'b1;
         #250 o_scl = 1'b1;
      end
      #250 o_sda = 1'b0;
      #400 in_frame = 1'b1;
   endtask

   // one byte out, msb first, data moved only while scl is low
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         o_scl = 1'b0;
         #250 o_sda = b[i];
         #250 o_scl = 1'b1;
         #300;
      end
      o_scl = 1'b0;
      #250 o_sda = 1'b1;
      #250 o_scl = 1'b1;
      #250 ack = ~i_sda;
      #50;
   endtask

   // one byte in; sda sampled late in the high phase, then our own ack level
   task automatic get_byte(input logic ack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         o_scl = 1'b0;
         #250 o_sda = 1'b1;
         #250 o_scl = 1'b1;
         #250 b[i] = i_sda;
         #50;
      end
      o_scl = 1'b0;
      #250 o_sda = ~ack;
      #250 o_scl = 1'b1;
      #300;
   endtask

   // end the current clock pulse and hold scl low
   task automatic scl_low();
      o_scl = 1'b0;
   endtask

   // stop: sda rises while scl is high
   task automatic stop_cond();
      o_scl = 1'b0;
      #250 o_sda = 1'b0;
      #250 o_scl = 1'b1;
      #250 o_sda = 1'b1;
      #400 in_frame = 1'b0;
   endtask
endmodule

// File: eefe_front_end.sv
`timescale 1ns/100ps

// plain synchronous fifo; full and empty come straight from the count
module eefe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output      logic             o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_out_valid,
   input  wire logic             i_out_ready,
   output      logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem[rd_ptr_reg];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // storage has no reset; only pointers and count carry state
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module eefe_front_end #(
   parameter logic [3:0] DEV_TYPE_ID = eefe_pkg::TYPE_ID_DFLT,  // arbitrary value
   parameter int         WR_CYCLES   = eefe_pkg::WR_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output      logic       o_sda_out,
   output      logic       o_sda_oe_n,
   input  wire logic       i_chip_sel_addr_bit2,
   input  wire logic       i_chip_sel_addr_bit1,
   input  wire logic       i_chip_sel_addr_bit0,
   input  wire logic       i_write_inhibit_n,
   input  wire logic       i_supply_ok,
   output      logic       o_standby,
   output      logic       o_busy,
   output      logic       o_wr_cycle_start,
   output      logic       o_read_dir,
   output      logic [15:0] o_word_addr,
   output      logic       o_wr_data_valid,
   input  wire logic       i_wr_data_ready,
   output      logic [7:0] o_wr_data,
   input  wire logic [7:0] i_rd_data,
   output      logic       o_rd_data_take
);
   localparam int BW = $clog2(WR_CYCLES + 1);

   logic [eefe_pkg::SYNC_W-1:0] meta_reg;
   logic [eefe_pkg::SYNC_W-1:0] sync_reg;
   logic                        scl_d_reg;
   logic                        sda_d_reg;
   logic                        scl;
   logic                        sda;
   logic                        rst_int;
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_det;
   logic                        stop_det;
   eefe_pkg::eefe_state_t       state_reg;
   logic [3:0]                  cnt_reg;
   logic [7:0]                  shift_reg;
   logic [7:0]                  tx_reg;
   logic                        drive_reg;
   logic                        mack_reg;
   logic                        wrote_reg;
   logic                        rnw_reg;
   logic [15:0]                 addr_reg;
   logic                        take_reg;
   logic [BW-1:0]               bsy_cnt_reg;
   logic                        wr_start_reg;
   logic                        busy;
   logic                        sel_match;
   logic                        fifo_ready;
   logic                        ack_ok;
   logic                        push;
   logic                        wr_trig;

   // two stages for every pin, straps and supply detector included
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= {i_supply_ok, i_write_inhibit_n, i_chip_sel_addr_bit2,
                      i_chip_sel_addr_bit1, i_chip_sel_addr_bit0, i_sda, i_scl};
         sync_reg <= meta_reg;
      end
   end

   // edge history reads only the second stage
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl;
         sda_d_reg <= sda;
      end
   end

   // bus events; start and stop need scl high on both samples
   assign scl       = sync_reg[eefe_pkg::IDX_SCL];
   assign sda       = sync_reg[eefe_pkg::IDX_SDA];
   assign rst_int   = i_rst | ~sync_reg[eefe_pkg::IDX_POR];
   assign scl_rise  = scl & ~scl_d_reg;
   assign scl_fall  = ~scl & scl_d_reg;
   assign start_det = scl & scl_d_reg & sda_d_reg & ~sda;
   assign stop_det  = scl & scl_d_reg & ~sda_d_reg & sda;
   assign busy      = (bsy_cnt_reg != '0);

   // open pads must be pulled low on the board so they compare as zero
   assign sel_match = (shift_reg[7:4] == DEV_TYPE_ID) &
                      (shift_reg[3:1] == sync_reg[eefe_pkg::IDX_CS2:eefe_pkg::IDX_CS0]);

   // ack decision for the byte just shifted in
   always_comb
   begin
      case (state_reg)
         eefe_pkg::ST_DEVSEL:  ack_ok = sel_match & ~busy;
         eefe_pkg::ST_ADDR_HI: ack_ok = 1'b1;
         eefe_pkg::ST_ADDR_LO: ack_ok = 1'b1;
         // a full fifo refuses the byte so nothing is lost silently
         eefe_pkg::ST_WDATA:   ack_ok = ~sync_reg[eefe_pkg::IDX_WINH] & fifo_ready;
         default:              ack_ok = 1'b0;
      endcase
   end

   assign push = (state_reg == eefe_pkg::ST_WDATA) & scl_fall & (cnt_reg == eefe_pkg::CNT_ACK) & ack_ok;

   // byte engine: start and stop win over any clock edge
   always_ff @(posedge i_clk)
   begin
      if (rst_int)
      begin
         state_reg <= eefe_pkg::ST_IDLE;
         cnt_reg   <= '0;
         shift_reg <= '0;
         tx_reg    <= '0;
         drive_reg <= 1'b0;
         mack_reg  <= 1'b0;
         rnw_reg   <= 1'b0;
         take_reg  <= 1'b0;
      end
      else
      begin
         take_reg <= 1'b0;
         if (start_det && !busy)
         begin
            state_reg <= eefe_pkg::ST_DEVSEL;
            cnt_reg   <= '0;
            drive_reg <= 1'b0;
         end
         else if (stop_det)
         begin
            state_reg <= eefe_pkg::ST_IDLE;
            drive_reg <= 1'b0;
         end
         else if (state_reg != eefe_pkg::ST_IDLE && scl_rise)
         begin
            if (cnt_reg < eefe_pkg::CNT_ACK)
            begin
               shift_reg <= {shift_reg[6:0], sda};
            end
            else
            begin
               mack_reg <= ~sda;  // master ack after a read byte
            end
            cnt_reg <= cnt_reg + 4'h1;
         end
         else if (state_reg != eefe_pkg::ST_IDLE && scl_fall)
         begin
            if (cnt_reg == eefe_pkg::CNT_ACK)
            begin
               drive_reg <= (state_reg != eefe_pkg::ST_RDATA) & ack_ok;
               if (state_reg == eefe_pkg::ST_DEVSEL)
               begin
                  rnw_reg <= shift_reg[0];
               end
            end
            else if (cnt_reg == eefe_pkg::CNT_END)
            begin
               cnt_reg   <= '0;
               drive_reg <= 1'b0;
               case (state_reg)
                  eefe_pkg::ST_DEVSEL:
                  begin
                     if (!drive_reg)
                     begin
                        state_reg <= eefe_pkg::ST_IDLE;
                     end
                     else if (rnw_reg)
                     begin
                        state_reg <= eefe_pkg::ST_RDATA;
                        tx_reg    <= i_rd_data;
                        drive_reg <= ~i_rd_data[7];
                        take_reg  <= 1'b1;
                     end
                     else
                     begin
                        state_reg <= eefe_pkg::ST_ADDR_HI;
                     end
                  end
                  eefe_pkg::ST_ADDR_HI: state_reg <= eefe_pkg::ST_ADDR_LO;
                  eefe_pkg::ST_ADDR_LO: state_reg <= eefe_pkg::ST_WDATA;
                  eefe_pkg::ST_RDATA:
                  begin
                     if (mack_reg)
                     begin
                        tx_reg    <= i_rd_data;
                        drive_reg <= ~i_rd_data[7];
                        take_reg  <= 1'b1;
                     end
                     else
                     begin
                        state_reg <= eefe_pkg::ST_IDLE;
                     end
                  end
                  default: state_reg <= state_reg;
               endcase
            end
            else if (state_reg == eefe_pkg::ST_RDATA)
            begin
               // next read bit; only zeros pull the line
               tx_reg    <= {tx_reg[6:0], 1'b0};
               drive_reg <= (cnt_reg == 4'h0) ? ~tx_reg[7] : ~tx_reg[6];
            end
         end
      end
   end

   // word address and write bookkeeping
   always_ff @(posedge i_clk)
   begin
      if (rst_int)
      begin
         addr_reg  <= '0;
         wrote_reg <= 1'b0;
      end
      else
      begin
         if (start_det)
         begin
            wrote_reg <= 1'b0;
         end
         else if (state_reg == eefe_pkg::ST_WDATA && scl_fall && cnt_reg == eefe_pkg::CNT_ACK)
         begin
            wrote_reg <= push;  // a refused last byte must not start a cycle
         end
         if (scl_fall && cnt_reg == eefe_pkg::CNT_ACK && state_reg == eefe_pkg::ST_ADDR_HI)
         begin
            addr_reg[15:8] <= shift_reg;
         end
         if (scl_fall && cnt_reg == eefe_pkg::CNT_ACK && state_reg == eefe_pkg::ST_ADDR_LO)
         begin
            addr_reg[7:0] <= shift_reg;
         end
      end
   end

   // the stop's own scl rise already counted one bit, so the slot after a data ack shows one
   assign wr_trig = stop_det & (state_reg == eefe_pkg::ST_WDATA) & (cnt_reg == 4'h1) & wrote_reg;

   // write cycle timer; while it runs starts are ignored and sda stays released
   always_ff @(posedge i_clk)
   begin
      if (rst_int)
      begin
         bsy_cnt_reg  <= '0;
         wr_start_reg <= 1'b0;
      end
      else
      begin
         wr_start_reg <= wr_trig;
         if (wr_trig)
         begin
            bsy_cnt_reg <= BW'(WR_CYCLES);
         end
         else if (busy)
         begin
            bsy_cnt_reg <= bsy_cnt_reg - 1'b1;
         end
      end
   end

   eefe_fifo #(
      .WIDTH (eefe_pkg::FIFO_WIDTH),
      .DEPTH (eefe_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (rst_int),
      .i_in_valid  (push),
      .o_in_ready  (fifo_ready),
      .i_in_data   (shift_reg),
      .o_out_valid (o_wr_data_valid),
      .i_out_ready (i_wr_data_ready),
      .o_out_data  (o_wr_data)
   );

   // open drain: data level fixed low, only the enable moves
   assign o_sda_out        = 1'b0;
   assign o_sda_oe_n       = ~drive_reg;
   assign o_standby        = (state_reg == eefe_pkg::ST_IDLE) & ~busy;
   assign o_busy           = busy;
   assign o_wr_cycle_start = wr_start_reg;
   assign o_read_dir       = rnw_reg;
   assign o_word_addr      = addr_reg;
   assign o_rd_data_take   = take_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (rst_int);

   sequence s_ack_slot;
      state_reg != eefe_pkg::ST_RDATA && scl_fall && cnt_reg == eefe_pkg::CNT_ACK && ack_ok;
   endsequence
   sequence s_wr_stop;
      stop_det && state_reg == eefe_pkg::ST_WDATA && cnt_reg == 4'h1 && wrote_reg;
   endsequence

   a_start_enters_sel: assert property (start_det && !busy |=> state_reg == eefe_pkg::ST_DEVSEL)
      else $error("start not taken");
   a_busy_ignores_start: assert property (busy && start_det |=> state_reg == eefe_pkg::ST_IDLE && o_sda_oe_n)
      else $error("start taken while busy");
   a_stop_ends_xfer: assert property (stop_det |=> state_reg == eefe_pkg::ST_IDLE && o_sda_oe_n)
      else $error("stop did not end transfer");
   a_write_cycle_start: assert property (s_wr_stop |=> o_wr_cycle_start && o_busy)
      else $error("write cycle not started");
   a_ack_driven: assert property (s_ack_slot |=> !o_sda_oe_n)
      else $error("ack not driven");
   a_inhibit_nack: assert property (state_reg == eefe_pkg::ST_WDATA && scl_fall && cnt_reg == eefe_pkg::CNT_ACK
                                     && sync_reg[eefe_pkg::IDX_WINH] |=> o_sda_oe_n)
      else $error("data acked under write inhibit");
   a_mismatch_nack: assert property (state_reg == eefe_pkg::ST_DEVSEL && scl_fall && cnt_reg == eefe_pkg::CNT_ACK
                                      && !sel_match |=> o_sda_oe_n)
      else $error("mismatched select acked");
   a_rx_capture: assert property (state_reg != eefe_pkg::ST_IDLE && scl_rise && cnt_reg < eefe_pkg::CNT_ACK
                                   |=> shift_reg[0] == $past(sda))
      else $error("bit not captured");
   a_rd_nack_idle: assert property (state_reg == eefe_pkg::ST_RDATA && scl_fall && cnt_reg == eefe_pkg::CNT_END
                                     && !mack_reg |=> state_reg == eefe_pkg::ST_IDLE)
      else $error("read nack did not release");
   a_supply_silence: assert property (@(posedge i_clk) disable iff (i_rst)
                                       !sync_reg[eefe_pkg::IDX_POR] |=> state_reg == eefe_pkg::ST_IDLE && o_sda_oe_n)
      else $error("bus answered below supply threshold");
endmodule

// File: eefe_front_end_tb_top.sv
`timescale 1ns/100ps

module eefe_front_end_tb_top;
   localparam logic [3:0] TYPE_ID = 4'h6;  // arbitrary value
   localparam int         WR      = 200;
   logic        i_clk, i_rst, scl, m_sda, o_sda_out, o_sda_oe_n;
   logic        i_write_inhibit_n, i_supply_ok, o_standby, o_busy;
   logic        o_wr_cycle_start, o_read_dir, o_wr_data_valid, o_rd_data_take;
   logic        i_wr_data_ready, drain_en;
   logic [2:0]  cs;
   logic [15:0] o_word_addr, wa;
   logic [7:0]  o_wr_data, i_rd_data;
   logic [7:0]  wq[$], rq[$];
   logic [7:0]  rd_last;
   logic [31:0] seed, r, r2;
   wire         sda;
   int          err_count, n_compared, n_starts, busy_cnt;

   // open-drain wire with pull-up
   assign sda = m_sda & (o_sda_oe_n | o_sda_out);

   eefe_front_end #(.DEV_TYPE_ID(TYPE_ID), .WR_CYCLES(WR)) eefe_front_end_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out),
      .o_sda_oe_n(o_sda_oe_n), .i_chip_sel_addr_bit2(cs[2]), .i_chip_sel_addr_bit1(cs[1]),
      .i_chip_sel_addr_bit0(cs[0]), .i_write_inhibit_n(i_write_inhibit_n),
      .i_supply_ok(i_supply_ok), .o_standby(o_standby), .o_busy(o_busy),
      .o_wr_cycle_start(o_wr_cycle_start), .o_read_dir(o_read_dir), .o_word_addr(o_word_addr),
      .o_wr_data_valid(o_wr_data_valid), .i_wr_data_ready(i_wr_data_ready),
      .o_wr_data(o_wr_data), .i_rd_data(i_rd_data), .o_rd_data_take(o_rd_data_take));

   eefe_bus_master eefe_bus_master_i (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));

   // 10 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask

   task automatic sync(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic tx(input logic [7:0] b, input logic exp, input string msg);
      logic a;
      eefe_bus_master_i.put_byte(b, a);
      chk(16'(a), 16'(exp), msg);
   endtask

   // read bytes are checked against what the take pulse captured
   task automatic rx(input logic ack);
      logic [7:0] b;
      eefe_bus_master_i.get_byte(ack, b);
      chk(16'(b), (rq.size() > 0) ? 16'(rq.pop_front()) : 16'hxxxx, "read byte");
   endtask

   task automatic st();
      eefe_bus_master_i.start_cond();
   endtask

   task automatic sp();
      eefe_bus_master_i.stop_cond();
      sync(1);
   endtask

   task automatic hdr(input logic [15:0] a);
      st();
      tx({TYPE_ID, cs, 1'b0}, 1'b1, "write select");
      tx(a[15:8], 1'b1, "addr hi");
      tx(a[7:0], 1'b1, "addr lo");
   endtask

   task automatic wait_idle();
      for (int k = 0; k < 1000 && o_standby !== 1'b1; k++)
         sync(1);
   endtask

   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // drain ready and read data move shortly after each edge
   always @(posedge i_clk)
   begin
      #1;
      r2 = $random(seed);
      i_wr_data_ready = drain_en & r2[0];
      i_rd_data = r2[15:8];
   end

   // watcher: pops noted buffer bytes, counts cycle starts and busy length
   always @(posedge i_clk)
   begin
      if (o_sda_oe_n === 1'b0)
         chk(16'(o_sda_out), 16'h0000, "sda driven high");
      if (o_wr_data_valid === 1'b1 && i_wr_data_ready === 1'b1)
         chk(16'(o_wr_data), (wq.size() > 0) ? 16'(wq.pop_front()) : 16'hxxxx, "buffer data");
      // the pulse shows one edge after the byte was taken, so note the byte of that edge
      if (o_rd_data_take === 1'b1)
         rq.push_back(rd_last);
      rd_last = i_rd_data;
      if (o_wr_cycle_start === 1'b1)
         n_starts++;
      if (o_busy === 1'b1)
         busy_cnt++;
      else if (busy_cnt != 0)
      begin
         chk(16'(busy_cnt), 16'(WR), "busy length");
         busy_cnt = 0;
      end
   end

   // watchdog, well beyond the expected run of about 0.5 ms
   initial
   begin
      #3000000;
      err_count++;
      $display("wrong value at %0t ns: run hung", $time);
      tally_and_finish();
   end

   initial
   begin
      seed = 32'h82e6693a;
      i_rst = 1'b1;
      i_write_inhibit_n = 1'b0;
      i_supply_ok = 1'b1;
      drain_en = 1'b1;
      i_wr_data_ready = 1'b0;
      i_rd_data = 8'h00;
      r = $random(seed);
      cs = r[2:0];
      wa = r[31:16];
      sync(16);
      i_rst = 1'b0;
      sync(20);
      chk(16'(o_standby), 16'h0001, "standby out of reset");
      chk(16'(o_sda_oe_n), 16'h0001, "sda released");
      // every single-bit error in chip or type field is refused
      for (int k = 0; k < 7; k++)
      begin
         st();
         tx({TYPE_ID, cs, 1'b0} ^ (8'h02 << k), 1'b0, "bad select");
         sp();
         chk(16'(o_standby), 16'h0001, "standby after mismatch");
      end
      // two-byte write, then a select while the write cycle runs
      hdr(wa);
      for (int k = 0; k < 2; k++)
      begin
         r = $random(seed);
         wq.push_back(r[7:0]);
         tx(r[7:0], 1'b1, "data ack");
      end
      chk(o_word_addr, wa, "word address");
      sp();
      sync(6);
      chk(16'(n_starts), 16'h0001, "write cycle start");
      st();
      tx({TYPE_ID, cs, 1'b0}, 1'b0, "select while busy");
      sp();
      wait_idle();
      // inhibited write: header acked, data refused, no cycle
      i_write_inhibit_n = 1'b1;
      hdr(wa + 16'h0020);
      tx(8'h5a, 1'b0, "inhibited data");
      sp();
      sync(20);
      chk(16'(o_busy), 16'h0000, "no write cycle");
      // random read with inhibit still high, ended by a nack
      hdr(wa);
      st();
      tx({TYPE_ID, cs, 1'b1}, 1'b1, "read select");
      chk(16'(o_read_dir), 16'h0001, "direction");
      rx(1'b1);
      rx(1'b0);
      // the device leaves on the scl fall that closes the nack slot, before any stop
      eefe_bus_master_i.scl_low();
      sync(8);
      chk(16'(o_standby), 16'h0001, "standby after nack");
      sp();
      // fill the buffer with the drain stalled until a byte is refused
      i_write_inhibit_n = 1'b0;
      drain_en = 1'b0;
      hdr(wa);
      for (int k = 0; k < 33; k++)
      begin
         r = $random(seed);
         if (k < 32)
            wq.push_back(r[7:0]);
         tx(r[7:0], k < 32, "buffer fill");
      end
      sp();
      drain_en = 1'b1;
      sync(300);
      chk(16'(wq.size()), 16'h0000, "buffer drained");
      chk(16'(n_starts), 16'h0001, "no cycle after refused byte");
      // supply drop silences the device; recovery answers again
      i_supply_ok = 1'b0;
      sync(4);
      st();
      tx({TYPE_ID, cs, 1'b1}, 1'b0, "select at low supply");
      sp();
      i_supply_ok = 1'b1;
      sync(10);
      st();
      tx({TYPE_ID, cs, 1'b0}, 1'b1, "select after recovery");
      sp();
      sync(8);
      chk(16'(o_standby), 16'h0001, "standby after stop");
      chk(16'(n_starts), 16'h0001, "no cycle without data");
      tally_and_finish();
   end
endmodule

// File: eefe_pkg.sv
// Summary of operation
// - select byte bits b3..b1 are compared with the three chip-select inputs
// - an unconnected chip-select input counts as zero in that comparison; here open pads need a pull-down on the board
// - write-inhibit high blocks array writes; low or open permits them; here an open input needs a pull-down on the board
// - with write-inhibit high, select and address bytes ack, write data bytes do not
// - bus is ignored until supply reset releases; release resets to standby
// - supply detector asserting at power-down stops all bus response
// - start is sda falling while scl high; master starts every transfer
// - start detection runs always except during an internal write cycle
// - stop is sda rising while scl high; it ends the communication
// - after an unacknowledged read byte a stop returns the device to standby; here it returns on the scl fall closing the nack slot
// - a stop terminating a write starts the internal write cycle; here only when the last data byte was acked
// - transmitter releases sda after eight bits; receiver pulls it low on ninth
// - received sda bits are captured on rising scl
// - upper four select bits must equal the type identifier or no ack
// - respond only when the three chip-select bits match the inputs
// - eighth select bit is direction: one read, zero write
// - full match acks in the ninth slot; mismatch releases bus to standby
// - reads ignore write-inhibit; writes of up to 32 bytes need it low
// - standby is entered after a stop when no write cycle runs
// - sda is only pulled low or released, never driven high
// - during a write cycle the sda driver is off and requests are ignored
// - after a write select ack, two address bytes are acked before data
package eefe_pkg;
   localparam int         CLK_PERIOD_NS = 100;
   localparam int         WR_TIME_US    = 1000;
   localparam int         WR_CYCLES     = (WR_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam logic [3:0] TYPE_ID_DFLT  = 4'h6;  // arbitrary value
   localparam logic [3:0] CNT_ACK       = 4'h8;  // bit count at the ack slot
   localparam logic [3:0] CNT_END       = 4'h9;  // bit count after the ack clock
   localparam int         FIFO_WIDTH    = 8;
   localparam int         FIFO_DEPTH    = 32;
   localparam int         SYNC_W        = 7;
   localparam int         IDX_SCL       = 0;
   localparam int         IDX_SDA       = 1;
   localparam int         IDX_CS0       = 2;
   localparam int         IDX_CS2       = 4;
   localparam int         IDX_WINH      = 5;
   localparam int         IDX_POR       = 6;
   typedef enum logic [2:0] {ST_IDLE, ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA} eefe_state_t;
endpackage
